// ===== rtl/mic_defs.svh
// Constants for the microstep indexer and chopping reference block.
// Assumes a 25 MHz clock and a 32-bit AXI4-Lite register port.
`ifndef MIC_DEFS_SVH
`define MIC_DEFS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define MIC_OFS_CTRL    8'h00
`define MIC_OFS_TORQUE  8'h04
`define MIC_OFS_OFF     8'h08
`define MIC_OFS_STATUS  8'h0c

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define MIC_CTRL_MODE_LSB   0
`define MIC_CTRL_INV_BIT    4
`define MIC_CTRL_GAIN_LSB   5
`define MIC_CTRL_SOFT_BIT   7
`define MIC_RST_MODE        4'h0
`define MIC_RST_TORQUE      8'hff
`define MIC_RST_OFF         8'h00
`define MIC_MODE_FINEST     4'h8
`define MIC_HOME_ANGLE      10'h080
`define MIC_RESP_OKAY       2'h0
`define MIC_RESP_SLVERR     2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define MIC_CLK_NS          40
`define MIC_OFF_TIME_FIELD_UNIT_NS    500
`define MIC_OFF_TIME_FIELD_UNIT_CYC   ((`MIC_OFF_TIME_FIELD_UNIT_NS + `MIC_CLK_NS - 1) / `MIC_CLK_NS)

`endif

// ===== rtl/mic_pkg.sv
// Types shared by the indexer, the sine table and the chopper.
// Assumes mic_defs.svh supplies the numeric constants.
package mic_pkg;

  // Chopper phases, one-hot
  typedef enum logic [1:0] {
    MIC_CHOP_ON  = 2'b01,
    MIC_CHOP_OFF = 2'b10
  } mic_chop_t;

  // Drive of one H-bridge winding
  typedef struct packed {
    logic first_hi;   // bridge_first_terminal positive
    logic second_hi;  // bridge_second_terminal positive
  } mic_drive_t;

  // Software control fields
  typedef struct packed {
    logic [1:0] gain;
    logic       invert;
    logic [3:0] mode;
  } mic_ctrl_t;

  // Signed table current of one winding
  typedef struct packed {
    logic       neg;
    logic [8:0] mag;
  } mic_cur_t;

endpackage : mic_pkg

// ===== rtl/mic_sine_lut.sv
// Sine lookup: quarter-wave table at 32 states per cycle with interpolation.
// Assumes a 10-bit angle, 1024 units per electrical cycle; purely combinational.
`include "mic_defs.svh"
module mic_sine_lut
  import mic_pkg::*;
(
  input  wire logic [9:0] angle,  // Electrical angle
  output mic_cur_t        cur     // Signed table magnitude, 256 = 100 %
);

  // Table points every 11.25 degrees, 256 full scale
  function automatic logic [8:0] mic_tab(input logic [3:0] i);
    case (i)
      4'h0:    mic_tab = 9'h000;
      4'h1:    mic_tab = 9'h032;
      4'h2:    mic_tab = 9'h062;
      4'h3:    mic_tab = 9'h08e;
      4'h4:    mic_tab = 9'h0b5;
      4'h5:    mic_tab = 9'h0d5;
      4'h6:    mic_tab = 9'h0ed;
      4'h7:    mic_tab = 9'h0fb;
      default: mic_tab = 9'h100;
    endcase
  endfunction : mic_tab

  // Fold the quadrant; odd quadrants mirror the phase
  wire logic [8:0]  ph     = angle[8] ? 9'h100 - {1'b0, angle[7:0]} : {1'b0, angle[7:0]};
  wire logic [3:0]  idx    = ph[8:5];
  wire logic [8:0]  lo     = mic_tab(idx);
  wire logic [8:0]  hi     = mic_tab(idx + 4'h1);
  wire logic [13:0] step_f = 14'(hi - lo) * 14'(ph[4:0]);
  wire logic [8:0]  mag    = lo + step_f[13:5];

  // Second half-cycle (angle[9] set) is negative; zero is never negative
  assign cur.mag = mag;
  assign cur.neg = angle[9] && (mag != 9'h000);

endmodule : mic_sine_lut

// ===== rtl/mic_chopper.sv
// Fixed off-time PWM chopper for one winding.
// Assumes a 520 ns tick enable and a synchronised sense code on the same clock.
`include "mic_defs.svh"
module mic_chopper
  import mic_pkg::*;
(
  input  wire logic       aclk,      // Clock
  input  wire logic       rst_n,     // Sync reset, active low
  input  wire logic       tick,      // One pulse per off-time unit
  input  wire logic [7:0] off_time,  // Off time in units, minus one
  input  wire mic_cur_t   ref_cur,   // Scaled reference and polarity
  input  wire logic [9:0] sense,     // Sense-resistor voltage code
  input  wire logic [5:0] gain,      // Amplifier gain
  output mic_drive_t      drive,     // Registered bridge drive
  output mic_chop_t       phase      // Current chopper phase
);

  logic [8:0] left;
  mic_chop_t  next_phase;

  // Amplified sense against the reference
  wire logic [15:0] amp   = 16'(sense) * 16'(gain);
  wire logic        trip  = amp >= {7'h00, ref_cur.mag};
  wire logic        done  = tick && (left == 9'h000);

  // R08 off-time sequencing
  always_comb begin
    case (phase)
      MIC_CHOP_ON:  next_phase = trip ? MIC_CHOP_OFF : MIC_CHOP_ON;
      MIC_CHOP_OFF: next_phase = done ? MIC_CHOP_ON : MIC_CHOP_OFF;
      default:      next_phase = MIC_CHOP_ON;
    endcase
  end

  // Phase, off counter and drive; unit count is off_time + 1
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      phase <= MIC_CHOP_ON;
      left  <= 9'h000;
      drive <= '0;
    end else begin
      phase <= next_phase;
      if (phase == MIC_CHOP_ON && trip)
        left <= {1'b0, off_time};
      else if (tick && left != 9'h000)
        left <= left - 9'h001;
      // R05 positive current drives the first terminal
      drive.first_hi  <= (next_phase == MIC_CHOP_ON) && !ref_cur.neg;
      drive.second_hi <= (next_phase == MIC_CHOP_ON) && ref_cur.neg;
    end
  end

endmodule : mic_chopper

// ===== rtl/mic_indexer.sv
// Microstep indexer with torque-scaled chopping reference and AXI4-Lite registers.
// Assumes step, heading, clear and sense inputs are asynchronous to aclk.
//
// Contract
// R01: Winding A target is the sine and winding B target the cosine of the angle.
// R02: Power-up or the clear pin puts the indexer at 45 degrees, both windings at 71 percent.
// R03: Each step rising edge or each soft-advance write of one advances one state.
// R04: Heading high with invert 0, or low with invert 1, steps forward; otherwise reverse.
// R05: Positive table current drives the first terminal positive against the second.
// R06: After a resolution change the next step lands on the next state valid for it.
// R07: Eighth step has 32 states per cycle; coarser ones use subsets, finer ones the same pattern.
// R08: At the chopping threshold the bridge is off for 500 ns to 128 us, then a new cycle starts; the code gives one cycle up to 256 units of 520 ns.
// R09: Threshold is sense voltage times amplifier gain compared with the reference.
// R10: Reference is the table output times the current scale, on a 2.75 V full-scale converter.
// R11: The gain field selects 5, 10, 20 or 40, with 0 meaning 5.
// R12: A four-bit field selects full step at 0000 down to 1/256 step at 1000.
// R13: Position wraps modulo one electrical cycle in both directions.
// R14: Reference scales linearly with the eight-bit current scale over 256.
`include "mic_defs.svh"
module mic_indexer
  import mic_pkg::*;
(
  input  wire logic        aclk,              // Clock, 25 MHz
  input  wire logic        aresetn,           // Sync reset, active low
  input  wire logic [7:0]  s_axi_awaddr,      // Write address
  input  wire logic        s_axi_awvalid,     // Write address valid
  output logic             s_axi_awready,     // Write address ready
  input  wire logic [31:0] s_axi_wdata,       // Write data
  input  wire logic [3:0]  s_axi_wstrb,       // Write strobes
  input  wire logic        s_axi_wvalid,      // Write data valid
  output logic             s_axi_wready,      // Write data ready
  output logic [1:0]       s_axi_bresp,       // Write response
  output logic             s_axi_bvalid,      // Write response valid
  input  wire logic        s_axi_bready,      // Write response ready
  input  wire logic [7:0]  s_axi_araddr,      // Read address
  input  wire logic        s_axi_arvalid,     // Read address valid
  output logic             s_axi_arready,     // Read address ready
  output logic [31:0]      s_axi_rdata,       // Read data
  output logic [1:0]       s_axi_rresp,       // Read response
  output logic             s_axi_rvalid,      // Read data valid
  input  wire logic        s_axi_rready,      // Read data ready
  input  wire logic        step_pin,          // Step input
  input  wire logic        heading_pin,       // Direction input
  input  wire logic        chip_clear_pin_n,  // Chip reset pin, active low
  input  wire logic [9:0]  sense_a_code,      // Winding A sense_resistor_pins code
  input  wire logic [9:0]  sense_b_code,      // Winding B sense_resistor_pins code
  output mic_drive_t       winding_a_output,  // Winding A bridge drive
  output mic_drive_t       winding_b_output,  // Winding B bridge drive
  output logic [8:0]       ref_a,             // Winding A reference code
  output logic [8:0]       ref_b              // Winding B reference code
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [2:0]  sync1;
  logic [2:0]  sync2;
  logic        step_d;
  logic [9:0]  sns_a1;
  logic [9:0]  sns_a2;
  logic [9:0]  sns_b1;
  logic [9:0]  sns_b2;

  // Two flops for each pin; sense codes assumed slow against the clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1  <= 3'h4;
      sync2  <= 3'h4;
      step_d <= 1'b0;
      sns_a1 <= 10'h000;
      sns_a2 <= 10'h000;
      sns_b1 <= 10'h000;
      sns_b2 <= 10'h000;
    end else begin
      sync1  <= {chip_clear_pin_n, heading_pin, step_pin};
      sync2  <= sync1;
      step_d <= sync2[0];
      sns_a1 <= sense_a_code;
      sns_a2 <= sns_a1;
      sns_b1 <= sense_b_code;
      sns_b2 <= sns_b1;
    end
  end

  wire logic step_s   = sync2[0];
  wire logic head_s   = sync2[1];
  wire logic clear_s  = !sync2[2];
  wire logic step_up  = step_s && !step_d;
  wire logic blk_rstn = aresetn && !clear_s;

  // ****************************************************************
  // Register file
  // ****************************************************************
  mic_ctrl_t   ctrl;
  logic [7:0]  torque;
  logic [7:0]  off_time;
  logic        soft_pulse;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [9:0]  angle;

  // Handshake: one write and one read in flight
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take  = s_axi_wvalid && s_axi_wready;
  wire logic [7:0]  wa   = aw_held ? aw_addr : s_axi_awaddr;
  wire logic [31:0] wd   = w_held ? w_data : s_axi_wdata;
  wire logic [3:0]  ws   = w_held ? w_strb : s_axi_wstrb;
  wire logic do_wr       = (aw_held || aw_take) && (w_held || w_take) && !s_axi_bvalid;
  wire logic wr_ctrl     = do_wr && ws[0] && (wa == `MIC_OFS_CTRL);
  wire logic wr_torque   = do_wr && ws[0] && (wa == `MIC_OFS_TORQUE);
  wire logic wr_off      = do_wr && ws[0] && (wa == `MIC_OFS_OFF);
  wire logic wr_mapped   = (wa == `MIC_OFS_CTRL) || (wa == `MIC_OFS_TORQUE) || (wa == `MIC_OFS_OFF);
  wire logic rd_mapped   = (s_axi_araddr == `MIC_OFS_CTRL) || (s_axi_araddr == `MIC_OFS_TORQUE) ||
                           (s_axi_araddr == `MIC_OFS_OFF) || (s_axi_araddr == `MIC_OFS_STATUS);

  // Write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MIC_RESP_OKAY;
    end else if (do_wr) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; the soft-advance bit is a pulse and reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl       <= '{gain: 2'h0, invert: 1'b0, mode: `MIC_RST_MODE};
      torque     <= `MIC_RST_TORQUE;
      off_time   <= `MIC_RST_OFF;
      soft_pulse <= 1'b0;
    end else begin
      soft_pulse <= wr_ctrl && wd[`MIC_CTRL_SOFT_BIT];
      if (wr_ctrl)
        ctrl <= wd[6:0];
      if (wr_torque)
        torque <= wd[7:0];
      if (wr_off)
        off_time <= wd[7:0];
    end
  end

  // Read data mux
  wire logic [31:0] rd_word =
    (s_axi_araddr == `MIC_OFS_CTRL)   ? {25'h0, ctrl} :
    (s_axi_araddr == `MIC_OFS_TORQUE) ? {24'h0, torque} :
    (s_axi_araddr == `MIC_OFS_OFF)    ? {24'h0, off_time} :
    (s_axi_araddr == `MIC_OFS_STATUS) ? {4'h0, ref_b, ref_a, angle} : 32'h0000_0000;

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `MIC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_mapped ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Indexer
  // ****************************************************************
  // R12 step size in 1/1024-cycle units; codes above 1000 act as 1/256
  function automatic logic [9:0] mic_step_size(input logic [3:0] mode);
    logic [3:0] m;
    m = (mode > `MIC_MODE_FINEST) ? `MIC_MODE_FINEST : mode;
    mic_step_size = 10'(10'h100 >> m);
  endfunction : mic_step_size

  // R07 1024 units per cycle; eighth step lands on every 32nd unit
  wire logic [9:0] inc      = mic_step_size(ctrl.mode);
  // Full step sits on the diagonals, half a step off the zero grid
  wire logic [9:0] grid_ofs = (ctrl.mode == 4'h0) ? 10'h080 : 10'h000;
  wire logic [9:0] aligned  = ((angle - grid_ofs) & ~(inc - 10'h001)) + grid_ofs;
  // R04 heading pin combined with invert bit
  wire logic       forward  = head_s ^ ctrl.invert;
  // R03 pin edge or software write advances once
  wire logic       advance  = step_up || soft_pulse;
  // R06 R13 snap to the new grid, wrapping in 10 bits
  wire logic [9:0] next_angle = forward ? aligned + inc :
                                (aligned != angle) ? aligned : angle - inc;

  // R02 home state after power-up or the clear pin
  always_ff @(posedge aclk) begin
    if (!blk_rstn)
      angle <= `MIC_HOME_ANGLE;
    else if (advance)
      angle <= next_angle;
  end

  // ****************************************************************
  // Reference and chopping
  // ****************************************************************
  mic_cur_t  tab_a;
  mic_cur_t  tab_b;
  mic_cur_t  cur_a;
  mic_cur_t  cur_b;
  mic_chop_t phase_a;
  mic_chop_t phase_b;
  logic [3:0] unit_cnt;

  // R01 sine for A, cosine for B by a quarter-cycle shift
  mic_sine_lut u_sin_a (
    .angle (angle),
    .cur   (tab_a)
  );
  mic_sine_lut u_sin_b (
    .angle (angle + 10'h100),
    .cur   (tab_b)
  );

  // R10 R14 table times current scale over 256; 256 codes span 2.75 V
  wire logic [16:0] prod_a = 17'(tab_a.mag) * 17'(torque);
  wire logic [16:0] prod_b = 17'(tab_b.mag) * 17'(torque);
  assign cur_a = '{neg: tab_a.neg, mag: prod_a[16:8]};
  assign cur_b = '{neg: tab_b.neg, mag: prod_b[16:8]};

  // R11 gain 5 shifted by the field
  function automatic logic [5:0] mic_gain(input logic [1:0] f);
    mic_gain = 6'(6'h05 << f);
  endfunction : mic_gain

  // Off-time unit divider; 500 ns rounds up to whole cycles
  localparam logic [3:0] UNIT_LAST = 4'(`MIC_OFF_TIME_FIELD_UNIT_CYC - 1);
  wire logic tick = (unit_cnt == UNIT_LAST);
  always_ff @(posedge aclk) begin
    if (!aresetn)
      unit_cnt <= 4'h0;
    else
      unit_cnt <= tick ? 4'h0 : unit_cnt + 4'h1;
  end

  // R09 each winding compares amplified sense with its reference
  mic_chopper u_chop_a (
    .aclk     (aclk),
    .rst_n    (blk_rstn),
    .tick     (tick),
    .off_time (off_time),
    .ref_cur  (cur_a),
    .sense    (sns_a2),
    .gain     (mic_gain(ctrl.gain)),
    .drive    (winding_a_output),
    .phase    (phase_a)
  );
  mic_chopper u_chop_b (
    .aclk     (aclk),
    .rst_n    (blk_rstn),
    .tick     (tick),
    .off_time (off_time),
    .ref_cur  (cur_b),
    .sense    (sns_b2),
    .gain     (mic_gain(ctrl.gain)),
    .drive    (winding_b_output),
    .phase    (phase_b)
  );

  // Reference codes registered for the converter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_a <= 9'h000;
      ref_b <= 9'h000;
    end else begin
      ref_a <= cur_a.mag;
      ref_b <= cur_b.mag;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_home_on_clear: assert property (!blk_rstn |=> angle == `MIC_HOME_ANGLE) // R02
    else $error("indexer not at home after clear");
  chk_home_level: assert property (angle == `MIC_HOME_ANGLE |-> tab_a.mag == tab_b.mag) // R02
    else $error("home state windings unequal");
  chk_sin_cos: assert property (angle == 10'h100 |-> tab_a.mag == 9'h100 && tab_b.mag == 9'h000) // R01
    else $error("sine cosine table misplaced");
  chk_adv_fwd: assert property (blk_rstn && advance && forward && angle == aligned
                                |=> angle == $past(angle) + $past(inc)) // R03
    else $error("forward advance wrong");
  chk_adv_rev: assert property (blk_rstn && advance && !forward && angle == aligned
                                |=> angle == $past(angle) - $past(inc)) // R04
    else $error("reverse advance wrong");
  chk_no_move: assert property (blk_rstn && !advance && $past(blk_rstn) |=> $stable(angle)) // R03
    else $error("angle moved without advance");
  chk_grid_snap: assert property (blk_rstn && advance |=> // R06
                                  ((angle - $past(grid_ofs)) & ($past(inc) - 10'h001)) == 10'h000)
    else $error("angle off the resolution grid");
  chk_full_diag: assert property (ctrl.mode == 4'h0 && advance |=> angle[7:0] == 8'h80) // R07
    else $error("full step not on diagonal");
  chk_polarity: assert property (winding_a_output.first_hi |-> !winding_a_output.second_hi) // R05
    else $error("both terminals driven");
  // A zero off-time field may end the off phase after one cycle, so it is left out
  chk_off_after_trip: assert property (disable iff (!blk_rstn) // R08
                                       off_time != 8'h00 && phase_a == MIC_CHOP_ON &&
                                       (16'(sns_a2) * 16'(mic_gain(ctrl.gain))) >= 16'(cur_a.mag)
                                       |=> phase_a == MIC_CHOP_OFF [*8])
    else $error("bridge reenabled too early");
  chk_ref_scale: assert property (tab_a.mag == 9'h100 |=> ref_a == {1'b0, $past(torque)}) // R14
    else $error("reference not scaled by torque");
  chk_gain_map: assert property (mic_gain(ctrl.gain) == ((ctrl.gain == 2'h0) ? 6'd5 : // R11
                                 (ctrl.gain == 2'h1) ? 6'd10 : (ctrl.gain == 2'h2) ? 6'd20 : 6'd40))
    else $error("gain field mapping wrong");

  cov_step_edge: cover property (step_up ##1 angle != `MIC_HOME_ANGLE);
  cov_soft_step: cover property (soft_pulse && !forward);
  cov_chop_cycle: cover property (phase_a == MIC_CHOP_OFF ##[1:400] phase_a == MIC_CHOP_ON);
  cov_wrap: cover property (advance && angle == 10'h080 && ctrl.mode == 4'h0 && !forward);

endmodule : mic_indexer

// ===== verif/mic_motion_ctl.sv
// Motion controller model: drives the step and heading pins of the indexer.
// Assumes the indexer samples both pins on aclk.
module mic_motion_ctl #(
  parameter int HALF = 48  // 1.9 us pulse width at 40 ns
) (
  input  wire logic aclk,        // Clock
  output logic      step_pin,    // Step output
  output logic      heading_pin  // Direction output
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    step_pin    = 1'b0;
    heading_pin = 1'b0;
  end

  // Heading settles 200 ns before the rising edge; both widths kept
  task automatic pulse(input logic dir);
    heading_pin <= dir;
    repeat (5) @(posedge aclk);
    step_pin <= 1'b1;
    repeat (HALF) @(posedge aclk);
    step_pin <= 1'b0;
    repeat (HALF) @(posedge aclk);
  endtask : pulse
endmodule : mic_motion_ctl

// ===== verif/tb.sv
// Self-checking bench for the indexer, its registers and the chopper.
// Assumes mic_motion_ctl drives step and heading; AXI driven here.
`include "mic_defs.svh"
module tb;
  import mic_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [3:0] mode; logic inv; logic head; logic [1:0] gain; logic [9:0] ang;} mic_row_t;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, chip_clear_pin_n = 1, step_pin, heading_pin;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [9:0] sense_a_code = 0, sense_b_code = 0;
  logic [8:0] ref_a, ref_b;
  mic_drive_t winding_a_output, winding_b_output;
  int miscompares = 0, checked = 0, n;
  localparam mic_row_t ROWS [11] = '{
    '{4'h3, 1'b0, 1'b1, 2'h0, 10'h0a0}, '{4'h1, 1'b0, 1'b1, 2'h1, 10'h100},
    '{4'h2, 1'b1, 1'b0, 2'h2, 10'h140}, '{4'h0, 1'b0, 1'b0, 2'h3, 10'h080},
    '{4'h0, 1'b1, 1'b1, 2'h0, 10'h380}, '{4'h0, 1'b0, 1'b1, 2'h0, 10'h080},
    '{4'h8, 1'b1, 1'b1, 2'h0, 10'h07f}, '{4'h4, 1'b0, 1'b1, 2'h0, 10'h080},
    '{4'h5, 1'b0, 1'b1, 2'h0, 10'h088}, '{4'h6, 1'b0, 1'b1, 2'h0, 10'h08c},
    '{4'h7, 1'b0, 1'b1, 2'h0, 10'h08e}};
  localparam logic [9:0] TRIP [4] = '{10'd26, 10'd13, 10'd7, 10'd4};

  always #20 aclk = ~aclk;

  mic_indexer u_mic_indexer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .step_pin,
    .heading_pin, .chip_clear_pin_n, .sense_a_code, .sense_b_code, .winding_a_output, .winding_b_output,
    .ref_a, .ref_b);
  mic_motion_ctl u_mic_motion_ctl (.aclk, .step_pin, .heading_pin);

  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Handshakes are seen at the falling edge, released after the rising one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    int k;
    {aw, w, b, k} = '0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!b && k < 200) begin
      @(negedge aclk);
      {aw, w, b, rsp} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid, s_axi_bresp};
      k++;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!b) chk(0, 1);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ar, r;
    int k;
    {ar, r, k} = '0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (!r && k < 200) begin
      @(negedge aclk);
      {ar, r, rsp, rdat} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata};
      k++;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!r) chk(0, 1);
  endtask : rd

  // Cycles with the winding A bridge in one state, bounded
  task automatic hold_a(input logic off);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (((winding_a_output == 2'b00) == off) && n < 200);
    @(posedge aclk);
  endtask : hold_a

  // ****************************************
  // Watchdog, reckoned well beyond the run
  // ****************************************
  initial begin
    #3000000;
    miscompares++;
    stop_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`MIC_OFS_CTRL);
    chk(rdat, 0);
    rd(`MIC_OFS_TORQUE);
    chk(rdat, `MIC_RST_TORQUE);
    rd(`MIC_OFS_STATUS);
    chk(rdat[9:0], `MIC_HOME_ANGLE);
    chk(ref_a, ref_b);
    rd(8'h10);
    chk({rsp, rdat}, {`MIC_RESP_SLVERR, 32'h0});
    wr(8'h10, 32'h1);
    chk(rsp, `MIC_RESP_SLVERR);
    for (int i = 0; i < 11; i++) begin
      wr(`MIC_OFS_CTRL, {ROWS[i].gain, ROWS[i].inv, ROWS[i].mode});
      u_mic_motion_ctl.pulse(ROWS[i].head);
      rd(`MIC_OFS_STATUS);
      chk(rdat[9:0], ROWS[i].ang);
      chk(winding_a_output, ROWS[i].ang[9] ? 2'b01 : 2'b10);
    end
    // Soft advance from 0x08e at eighth step lands on 0x0a0
    wr(`MIC_OFS_CTRL, 32'h83);
    rd(`MIC_OFS_STATUS);
    chk(rdat[9:0], 10'h0a0);
    rd(`MIC_OFS_CTRL);
    chk(rdat, 32'h03);
    repeat (3) u_mic_motion_ctl.pulse(1'b1);
    chk({ref_a, ref_b}, {9'd255, 9'd0});
    wr(`MIC_OFS_TORQUE, 32'h80);
    wr(`MIC_OFS_OFF, 32'h02);
    repeat (4) @(posedge aclk);
    chk(ref_a, 9'd128);
    // Threshold just below and just at sense times gain, per gain code
    for (int g = 0; g < 4; g++) begin
      wr(`MIC_OFS_CTRL, {g[1:0], 5'h03});
      sense_a_code <= TRIP[g] - 10'd1;
      repeat (60) @(posedge aclk);
      chk(winding_a_output, 2'b10);
      sense_a_code <= TRIP[g];
      hold_a(1'b0);
      chk(n < 12, 1);
    end
    hold_a(1'b1);
    chk(n >= 2 * `MIC_OFF_TIME_FIELD_UNIT_CYC + 1 && n <= 3 * `MIC_OFF_TIME_FIELD_UNIT_CYC, 1);
    sense_a_code <= 10'd0;
    chip_clear_pin_n <= 1'b0;
    repeat (4) @(posedge aclk);
    chip_clear_pin_n <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(`MIC_OFS_STATUS);
    chk(rdat[9:0], `MIC_HOME_ANGLE);
    chk(winding_b_output, 2'b10);
    rd(`MIC_OFS_TORQUE);
    chk(rdat, 32'h80);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`MIC_OFS_TORQUE);
    chk(rdat, `MIC_RST_TORQUE);
    stop_test();
  end
endmodule : tb
